// ---- logic/fetch_decode_pkg.sv ----
// Shared constants and carrier types of the fetch and operand decode block
package fetch_decode_pkg;
    localparam int PC_W            = 21;
    localparam int DADDR_W         = 12;
    localparam int WORD_W          = 16;
    localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
    localparam logic [PC_W-1:0] PC_STEP  = 21'h000002;
    localparam logic [3:0] SECOND_WORD_TAG = 4'hf;
    localparam logic [5:0] ADD_OP_PAT      = 6'h09;
    localparam logic [7:0] FORCED_LIMIT    = 8'h60;
    localparam logic [3:0] FORCED_BANK     = 4'hf;
    localparam logic [7:0] CALL_OP   = 8'hec;  // Upper byte, low bit is fast flag
    localparam logic [7:0] GOTO_OP   = 8'hef;
    localparam logic [3:0] MOVE_PAIR_OP = 4'hc;
    localparam logic [7:0] PTR_LOAD_OP  = 8'hee;
    localparam logic [3:0] BRA_OP    = 4'hd;   // 1101 0nnn: bra, 1101 1nnn: rcall

    typedef enum logic [3:0] {
        ST_FIRST  = 4'b0001,
        ST_SECOND = 4'b0010,
        ST_HOLD   = 4'b0100,
        ST_IDLE   = 4'b1000
    } fetch_state_t;

    typedef struct packed {
        logic               valid;
        logic [DADDR_W-1:0] addr;
        logic               dest;
        logic [1:0]         mode;  // 0 forced, 1 indexed, 2 banked, 3 access
    } operand_t;

    typedef struct packed {
        logic        valid;
        logic        isNop;
        logic        twoWord;
        logic [WORD_W-1:0] first;
        logic [WORD_W-1:0] second;
    } instr_t;
endpackage

// ---- logic/instr_fetch_operand_decode.sv ----
// Fetch alignment, branch target and byte operand address decode
// What this block does
// RULE1 - Instruction words sit at even byte addresses
// RULE2 - Counter steps by two, bit zero zero
// RULE3 - Absolute targets load counter bits 20:1
// RULE4 - Relative offsets count single words
// RULE5 - Recognise four two-word instructions
// RULE6 - Lone 1111 word executes as no-operation
// RULE7 - Sequenced second word feeds its first
// RULE8 - Decode add pattern 0010 01da ffff ffff
// RULE9 - Extended, a=0, f>=60h: forced bank 15
// RULE10 - Forced mode never reaches below 060h
// RULE11 - a=0, f<=5Fh: field plus pointer two; with extended clear the code uses the access bank (bank 0)
// RULE12 - a=1: bank select register chooses bank
// RULE13 - Indexed offset only with extended set
`timescale 1ns/1ps
module instr_fetch_operand_decode (
    input  wire logic                              clk,
    input  wire logic                              arst_n,
    input  wire logic                              extendedEnable,
    input  wire logic                              skipNext,
    input  wire logic [fetch_decode_pkg::WORD_W-1:0] fetchWord,
    input  wire logic                              fetchValid,
    input  wire logic [fetch_decode_pkg::DADDR_W-1:0] indirect_pointer_two,
    input  wire logic [3:0]                        bank_select_register,
    output logic [fetch_decode_pkg::PC_W-1:0]      program_counter,
    output fetch_decode_pkg::instr_t               instrOut,
    output fetch_decode_pkg::operand_t             operandOut
);
    import fetch_decode_pkg::*;

    fetch_state_t      state_r;
    logic [PC_W-1:0]   pc_r;
    logic [PC_W-1:0]   pc_nxt;
    logic [WORD_W-1:0] firstWord_r;
    logic              skipPending_r;
    instr_t            instr_r;
    operand_t          operand_r;
    logic              isTwoWordFirst;
    logic              isTail;
    logic              executeNow;
    logic              headIsJump;
    logic              wordIsBranch;
    logic              issuePair;
    logic              issueSingle;
    logic              issueNop;
    logic [PC_W-1:0]   jumpTarget;
    logic [PC_W-1:0]   branchTarget;
    operand_t          operand_nxt;

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------

    // Call head, either value of the fast flag
    function automatic logic isCallHead(input logic [WORD_W-1:0] w);
        isCallHead = (w[15:9] == CALL_OP[7:1]);                             // RULE5
    endfunction

    // Goto head
    function automatic logic isGotoHead(input logic [WORD_W-1:0] w);
        isGotoHead = (w[15:8] == GOTO_OP);                                  // RULE5
    endfunction

    // File-to-file move head
    function automatic logic isMoveHead(input logic [WORD_W-1:0] w);
        isMoveHead = (w[15:12] == MOVE_PAIR_OP);                            // RULE5
    endfunction

    // Pointer literal load head
    function automatic logic isLoadHead(input logic [WORD_W-1:0] w);
        isLoadHead = (w[15:8] == PTR_LOAD_OP);                              // RULE5
    endfunction

    // Heads whose pair loads an absolute target
    function automatic logic isJumpHead(input logic [WORD_W-1:0] w);
        isJumpHead = isCallHead(w) || isGotoHead(w);                        // RULE3
    endfunction

    // First word of a two-word instruction
    function automatic logic twoWordHead(input logic [WORD_W-1:0] w);
        twoWordHead = isJumpHead(w) || isMoveHead(w) || isLoadHead(w);      // RULE5
    endfunction

    // Tail tag, also the lone no-operation form
    function automatic logic isTailWord(input logic [WORD_W-1:0] w);
        isTailWord = (w[15:12] == SECOND_WORD_TAG);                         // RULE5 RULE6
    endfunction

    // Relative branch, with or without return
    function automatic logic isBranchWord(input logic [WORD_W-1:0] w);
        isBranchWord = (w[15:12] == BRA_OP);                                // RULE4
    endfunction

    // Sign-extended relative offset in bytes from a word count
    function automatic logic [PC_W-1:0] relBytes(input logic [10:0] n);
        relBytes = {{(PC_W-12){n[10]}}, n, 1'b0};                         // RULE4
    endfunction

    // Absolute byte target from the head and tail literals
    function automatic logic [PC_W-1:0] jumpBytes(input logic [WORD_W-1:0] head, input logic [WORD_W-1:0] tail);
        jumpBytes = {tail[11:0], head[7:0], 1'b0};                          // RULE3
    endfunction

    // Add-to-register pattern
    function automatic logic isAddWord(input logic [WORD_W-1:0] w);
        isAddWord = (w[15:10] == ADD_OP_PAT);                               // RULE8
    endfunction

    // Register field in the forced bank window
    function automatic logic isForcedField(input logic [7:0] f);
        isForcedField = (f >= FORCED_LIMIT);                                // RULE9 RULE10
    endfunction

    // Forced bank address, never below the window
    function automatic logic [DADDR_W-1:0] forcedAddr(input logic [7:0] f);
        forcedAddr = {FORCED_BANK, f};                                      // RULE9 RULE10
    endfunction

    // Field added to pointer two, wraps in data space
    function automatic logic [DADDR_W-1:0] indexedAddr(input logic [DADDR_W-1:0] ptr, input logic [7:0] f);
        indexedAddr = DADDR_W'(ptr + {4'h0, f});                            // RULE11
    endfunction

    // Field inside the bank chosen by the bank select register
    function automatic logic [DADDR_W-1:0] bankedAddr(input logic [3:0] bank, input logic [7:0] f);
        bankedAddr = {bank, f};                                             // RULE12
    endfunction

    // Conventional access bank: low part in bank 0, high part in bank 15
    function automatic logic [DADDR_W-1:0] accessAddr(input logic [7:0] f);
        accessAddr = isForcedField(f) ? forcedAddr(f) : {4'h0, f};          // RULE13
    endfunction

    // Byte operand address for the add-to-register pattern
    function automatic operand_t opAddr(input logic [WORD_W-1:0] w, input logic ext,
                                        input logic [DADDR_W-1:0] ptr, input logic [3:0] bank);
        operand_t o;
        o = '0;
        o.valid = isAddWord(w);                                             // RULE8
        o.dest  = w[9];
        if (w[8]) begin
            o.addr = bankedAddr(bank, w[7:0]);                              // RULE12
            o.mode = 2'd2;
        end else if (ext && isForcedField(w[7:0])) begin
            o.addr = forcedAddr(w[7:0]);                                    // RULE9 RULE10
            o.mode = 2'd0;
        end else if (ext) begin
            o.addr = indexedAddr(ptr, w[7:0]);                              // RULE11 RULE13
            o.mode = 2'd1;
        end else begin
            o.addr = accessAddr(w[7:0]);                                    // RULE13
            o.mode = 2'd3;
        end
        return o;
    endfunction

    // ------------------------------------------------------------
    // Combinational fetch decisions
    // ------------------------------------------------------------

    // A tail word executes alone when not preceded by its head
    assign isTail         = isTailWord(fetchWord);
    assign isTwoWordFirst = twoWordHead(fetchWord);
    assign executeNow     = fetchValid && !skipPending_r;

    // Absolute and relative targets for the counter
    assign headIsJump     = isJumpHead(firstWord_r);
    assign wordIsBranch   = isBranchWord(fetchWord);
    assign jumpTarget     = jumpBytes(firstWord_r, fetchWord);                  // RULE3
    assign branchTarget   = PC_W'(pc_r + PC_STEP + relBytes(fetchWord[10:0]));  // RULE4

    // Issue decisions: a pair completes or one word stands alone
    assign issuePair      = fetchValid && state_r == ST_SECOND;                 // RULE7
    assign issueSingle    = fetchValid && state_r == ST_FIRST && !(isTwoWordFirst && !skipPending_r);
    assign issueNop       = skipPending_r || isTail;                            // RULE6

    // Next counter value, always even
    always_comb begin
        pc_nxt = pc_r;
        if (fetchValid) begin
            pc_nxt = PC_W'(pc_r + PC_STEP);                                 // RULE2
            if (state_r == ST_SECOND && !skipPending_r) begin
                if (headIsJump) begin
                    pc_nxt = jumpTarget;                                    // RULE3
                end
            end else if (state_r == ST_FIRST && executeNow && wordIsBranch) begin
                pc_nxt = branchTarget;                                      // RULE4
            end
        end
        pc_nxt[0] = 1'b0;                                                   // RULE1 RULE2
    end

    // ------------------------------------------------------------
    // Sequencing
    // ------------------------------------------------------------

    // Fetch state: first word or awaited second word
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= ST_IDLE;
        end else begin
            case (state_r)
                ST_IDLE:   state_r <= ST_FIRST;
                ST_FIRST: begin
                    if (fetchValid && isTwoWordFirst && !isTail && !skipPending_r) begin // RULE6
                        state_r <= ST_SECOND;                               // RULE7
                    end
                end
                ST_SECOND: begin
                    if (fetchValid) begin
                        state_r <= ST_FIRST;
                    end
                end
                ST_HOLD:   state_r <= ST_FIRST;
                default:   state_r <= ST_FIRST;
            endcase
        end
    end

    // Program counter
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pc_r <= PC_RESET;
        end else begin
            pc_r <= pc_nxt;
        end
    end

    // Skip request covers the next fetched word only; one arriving with the fetch of an unskipped pair head is dropped
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            skipPending_r <= 1'b0;
        end else if (fetchValid) begin
            skipPending_r <= skipNext && !(state_r == ST_FIRST && isTwoWordFirst && !skipPending_r);
        end else if (skipNext) begin
            skipPending_r <= 1'b1;
        end
    end

    // Hold the head word while the tail arrives
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            firstWord_r <= '0;
        end else if (fetchValid && state_r == ST_FIRST) begin
            firstWord_r <= fetchWord;
        end
    end

    // ------------------------------------------------------------
    // Issue
    // ------------------------------------------------------------

    // Issued instruction
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            instr_r <= '0;
        end else begin
            instr_r <= '0;
            if (issuePair) begin
                instr_r.valid   <= 1'b1;
                instr_r.twoWord <= 1'b1;
                instr_r.isNop   <= skipPending_r;
                instr_r.first   <= firstWord_r;
                instr_r.second  <= fetchWord;                               // RULE7
            end else if (issueSingle) begin
                instr_r.valid <= 1'b1;
                instr_r.isNop <= issueNop;                                  // RULE6
                instr_r.first <= fetchWord;
            end
        end
    end

    // ------------------------------------------------------------
    // Operand decode
    // ------------------------------------------------------------

    // Operand of a single add word, valid low otherwise
    always_comb begin
        operand_nxt = '0;
        if (executeNow && state_r == ST_FIRST && !isTail) begin
            operand_nxt = opAddr(fetchWord, extendedEnable, indirect_pointer_two,
                                 bank_select_register);
        end
    end

    // Operand register, one-cycle valid pulse
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            operand_r <= '0;
        end else begin
            operand_r <= operand_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------

    // Outputs straight from their registers
    assign program_counter = pc_r;
    assign instrOut        = instr_r;
    assign operandOut      = operand_r;
endmodule

// ---- dv/instr_fetch_operand_decode_sva.sv ----
// Port assertions for the fetch and operand decode block
`timescale 1ns/1ps
module instr_fetch_operand_decode_sva (
    input wire logic                      clk,
    input wire logic                      arst_n,
    input wire logic                      extendedEnable,
    input wire logic                      skipNext,
    input wire logic [15:0]               fetchWord,
    input wire logic                      fetchValid,
    input wire logic [11:0]               indirect_pointer_two,
    input wire logic [3:0]                bank_select_register,
    input wire logic [20:0]               program_counter,
    input wire fetch_decode_pkg::instr_t   instrOut,
    input wire fetch_decode_pkg::operand_t operandOut
);
    import fetch_decode_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // Short views of the issued instruction
    wire [15:0] w   = instrOut.first;
    wire [15:0] s   = instrOut.second;
    wire [20:0] pc  = program_counter;
    wire        v   = instrOut.valid;
    wire        two = instrOut.twoWord;
    sequence s_issue;
        v && !instrOut.isNop;
    endsequence
    a_pc_even: assert property (pc[0] == 1'b0)
        else $error("counter odd");
    a_pc_step: assert property (v && !two && w[15:12] != BRA_OP |-> pc == $past(pc) + PC_STEP)
        else $error("counter step wrong");
    a_jump_target: assert property (v && two && (w[15:8] == GOTO_OP || w[15:9] == CALL_OP[7:1])
        |-> pc == {s[11:0], w[7:0], 1'b0}) else $error("jump target wrong");
    a_branch_words: assert property (s_issue ##0 w[15:11] == 5'h1a
        |-> pc == $past(pc) + PC_STEP + {{9{w[10]}}, w[10:0], 1'b0}) else $error("branch target wrong");
    a_tail_tag: assert property (v && two |-> s[15:12] == SECOND_WORD_TAG)
        else $error("pair tail tag wrong");
    a_add_decode: assert property (s_issue ##0 w[15:10] == ADD_OP_PAT
        |-> operandOut.valid && operandOut.dest == w[9]) else $error("add not decoded");
    a_mode_pick: assert property (operandOut.valid |-> operandOut.mode == (w[8] ? 2'd2 :
        !$past(extendedEnable) ? 2'd3 : w[7:0] >= FORCED_LIMIT ? 2'd0 : 2'd1)) else $error("mode wrong");
    a_indexed_sum: assert property (operandOut.valid && operandOut.mode == 2'd1
        |-> operandOut.addr == $past(indirect_pointer_two) + {4'h0, w[7:0]}) else $error("indexed wrong");
    a_banked_addr: assert property (operandOut.valid && operandOut.mode == 2'd2
        |-> operandOut.addr == {$past(bank_select_register), w[7:0]}) else $error("banked wrong");
    a_lone_nop: assert property (v && !two && w[15:12] == SECOND_WORD_TAG |-> instrOut.isNop)
        else $error("lone tail not nop");
    a_forced_floor: assert property (operandOut.valid && operandOut.mode == 2'd0
        |-> operandOut.addr[11:8] == FORCED_BANK && operandOut.addr[7:0] >= FORCED_LIMIT)
        else $error("forced below window");
endmodule
bind instr_fetch_operand_decode instr_fetch_operand_decode_sva chk_u (.clk, .arst_n, .extendedEnable,
    .skipNext, .fetchWord, .fetchValid, .indirect_pointer_two, .bank_select_register, .program_counter,
    .instrOut, .operandOut);

// ---- dv/prog_mem_model.sv ----
// Program memory model serving the word at the counter
`timescale 1ns/1ps
module prog_mem_model (
    input  wire logic [20:0] program_counter,
    output logic [15:0]      fetchWord
);
    logic [15:0] mem [0:31] = '{default: 16'h0};
    // Word read, bit zero of the byte address ignored
    assign fetchWord = mem[program_counter[5:1]];
endmodule

// ---- dv/instr_fetch_operand_decode_test.sv ----
// Self-checking bench for fetch alignment and operand decode
`timescale 1ns/1ps
module instr_fetch_operand_decode_test;
    import fetch_decode_pkg::*;
    logic        clk = 0, arst_n = 0, extendedEnable = 1, skipNext = 0, fetchValid = 0;
    logic [15:0] fetchWord;
    logic [11:0] indirect_pointer_two = 12'h1f0;
    logic [3:0]  bank_select_register = 4'h5;
    logic [20:0] program_counter;
    instr_t      instrOut;
    operand_t    operandOut;
    int          bad_count = 0, checks_done = 0;
    logic [15:0] prog [19] = '{16'h0e55, 16'hef03, 16'hf000, 16'hf123, 16'hd002, 16'h2465, 16'h2410,
        16'h2565, 16'h2460, 16'h265f, 16'h6600, 16'hc123, 16'hf456, 16'hc123, 16'hf456, 16'hee21,
        16'hf0ab, 16'hec05, 16'hf000};
    always #20 clk = ~clk;
    instr_fetch_operand_decode dut_u (.clk, .arst_n, .extendedEnable, .skipNext, .fetchWord, .fetchValid,
        .indirect_pointer_two, .bank_select_register, .program_counter, .instrOut, .operandOut);
    prog_mem_model mem_u (.program_counter, .fetchWord);
    task automatic chk(input logic ok, input string m);
        checks_done++;
        if (!ok) begin
            bad_count++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    function automatic operand_t o(input logic [11:0] a, input logic d, input logic [1:0] m);
        return {1'b1, a, d, m};
    endfunction
    // One fetch of n words, then counter, issue flags and operand
    task automatic step(input int n, input logic [20:0] pc, input logic [2:0] f, input operand_t op);
        @(posedge clk);
        #1 fetchValid = 1;
        repeat (n) @(posedge clk);
        #1 fetchValid = 0;
        chk(program_counter === pc, "counter");
        chk({instrOut.valid, instrOut.isNop, instrOut.twoWord} === f, "issue flags");
        chk(op.valid ? operandOut === op : operandOut.valid === 1'b0, "operand");
    endtask
    task automatic t_align_jump();
        step(1, 21'h2, 3'b100, '0);
        step(2, 21'h6, 3'b101, '0);
        chk(instrOut.second === 16'hf000, "goto tail");
        step(1, 21'h8, 3'b110, '0);
        step(1, 21'he, 3'b100, '0);
        $display("align and jump done");
    endtask
    task automatic t_operands();
        step(1, 21'h10, 3'b100, o(12'h565, 1'b0, 2'd2));
        step(1, 21'h12, 3'b100, o(12'hf60, 1'b0, 2'd0));
        step(1, 21'h14, 3'b100, o(12'h24f, 1'b1, 2'd1));
        $display("operand modes done");
    endtask
    task automatic t_skip_pairs();
        @(posedge clk);
        #1 fetchValid = 1;
        skipNext = 1;
        @(posedge clk);
        #1 fetchValid = 0;
        skipNext = 0;
        chk(instrOut.valid === 1'b1 && program_counter === 21'h16, "skip test issue");
        step(1, 21'h18, 3'b110, '0);
        step(1, 21'h1a, 3'b110, '0);
        step(2, 21'h1e, 3'b101, '0);
        chk(instrOut.second === 16'hf456, "move tail");
        step(2, 21'h22, 3'b101, '0);
        step(2, 21'ha, 3'b101, '0);
        $display("skip and pairs done");
    endtask
    task automatic t_legacy();
        extendedEnable = 0;
        step(1, 21'hc, 3'b100, o(12'hf65, 1'b0, 2'd3));
        step(1, 21'he, 3'b100, o(12'h010, 1'b0, 2'd3));
        $display("legacy access done");
    endtask
    task automatic end_of_test();
        $display("checks %0d bad %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Main sequence
    initial begin
        foreach (prog[i]) mem_u.mem[i] = prog[i];
        repeat (6) @(posedge clk);
        chk(program_counter === 21'h0 && instrOut.valid === 1'b0, "reset");
        #1 arst_n = 1;
        t_align_jump();
        t_operands();
        t_skip_pairs();
        t_legacy();
        end_of_test();
    end
    // Watchdog
    initial begin
        #20000;
        bad_count++;
        end_of_test();
    end
endmodule
